//--- hfs_defines.svh
/*
 * Register offsets, status bit positions, reset values and bus response
 * codes of the header field, status and test-bus register bank.
 * Assumes inclusion by bare name from every file that needs it.
 */
`ifndef HFS_DEFINES_SVH
`define HFS_DEFINES_SVH

// Byte addresses on the register bus
`define HFS_A_SFD_TIMER 8'h3C
`define HFS_A_SIG_CODE0 8'h40
`define HFS_A_SIG_CODE3 8'h4C
`define HFS_A_TX_RATE 8'h50
`define HFS_A_TX_SERVICE 8'h54
`define HFS_A_TX_LEN_HI 8'h58
`define HFS_A_TX_LEN_LO 8'h5C
`define HFS_A_RX_STATUS 8'h60
`define HFS_A_RX_SERVICE 8'h64
`define HFS_A_RX_LEN_HI 8'h68
`define HFS_A_RX_LEN_LO 8'h6C
`define HFS_A_TB_SELECT 8'h70
`define HFS_A_TB_MONITOR 8'h74

// Receive status bit positions
`define HFS_ST_RATE_HI 7
`define HFS_ST_RATE_LO 6
`define HFS_ST_ACQ 5
`define HFS_ST_SFD 4
`define HFS_ST_SIG 3
`define HFS_ST_CRC 2
`define HFS_ST_ANT 1

// Reset values
`define HFS_RST_BYTE 8'h00
`define HFS_RST_CODE0 8'h0A
`define HFS_RST_CODE1 8'h14
`define HFS_RST_CODE2 8'h37
`define HFS_RST_CODE3 8'h6E
`define HFS_RST_SFD_TIMER 8'h40

// Bus responses
`define HFS_RESP_OKAY 2'b00
`define HFS_RESP_SLVERR 2'b10

`endif

//--- hfs_pkg.sv
/*
 * Types of the header field, status and test-bus register bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package hfs_pkg;

    typedef enum logic [1:0] {
        HFS_RATE_1M = 2'b00,
        HFS_RATE_2M = 2'b01,
        HFS_RATE_5M5 = 2'b10,
        HFS_RATE_11M = 2'b11
    } hfs_rate_t;

    typedef enum logic [1:0] {
        HFS_SRCH_IDLE = 2'b00,
        HFS_SRCH_SFD = 2'b01,
        HFS_SRCH_FOUND = 2'b10
    } hfs_srch_t;

    typedef enum logic [7:0] {
        HFS_TB_QUIET = 8'h00,
        HFS_TB_RX = 8'h01,
        HFS_TB_TX = 8'h02,
        HFS_TB_STRENGTH = 8'h03
    } hfs_tb_code_t;

endpackage

//--- hfs_test_bus.sv
/*
 * Test-bus selector: routes one monitor group to the eight test lines
 * and the test clock. Output is combinational; the caller registers it.
 * Assumes all monitor inputs are synchronous to aclk.
 */
`timescale 1ns/1ps

module hfs_test_bus (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Selection
    input wire hfs_pkg::hfs_tb_code_t sel,
    // Monitor groups
    input wire logic [7:0] rx_mon,
    input wire logic [7:0] tx_mon,
    input wire logic symbol_boundary_mark,
    input wire logic carrier_sense_early,
    input wire logic strength_pulse,
    input wire logic [5:0] strength,
    input wire logic strength_conv_clk,
    // Test bus
    output logic [7:0] test_data,
    output logic test_clk
);
    import hfs_pkg::*;

    logic cse_latched_r;

    ////////////////////////////////////////////////////////////////////////
    // Early carrier sense is frozen at each strength sample
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cse_latched_r <= 1'b0;
        end else if (strength_pulse) begin
            cse_latched_r <= carrier_sense_early;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Unlisted codes stay quiet rather than showing stale data
    always_comb begin
        case (sel)
            HFS_TB_QUIET: begin
                test_data = 8'h00;
                test_clk = 1'b0;
            end
            HFS_TB_RX: begin
                test_data = rx_mon;
                test_clk = 1'b0;
            end
            HFS_TB_TX: begin
                test_data = tx_mon;
                test_clk = symbol_boundary_mark;
            end
            HFS_TB_STRENGTH: begin
                test_data = {cse_latched_r, carrier_sense_early,
                             strength};
                test_clk = strength_conv_clk;
            end
            default: begin
                test_data = 8'h00;
                test_clk = 1'b0;
            end
        endcase
    end

endmodule

//--- hfs_regs.sv
/*
 * Header field, receive status and test-bus register bank behind an
 * AXI4-Lite slave. Holds transmit header fields, reports receive header
 * status, times the delimiter search and drives the test bus.
 * Assumes header-path strobes are one-cycle pulses aligned to chips.
 */
`timescale 1ns/1ps
`include "hfs_defines.svh"

// Function
// - Transmit length bits 15..8 come from the high length register.
// - Transmit length bits 7..0 come from the low length register.
// - Receive status is read-only; its bit 0 reads zero.
// - Status bits 7:6 give the detected rate code.
// - Status bit 5 shows carrier acquired; zero while receive disabled.
// - Status bit 4 shows delimiter found; zero while receive disabled.
// - Status bit 3 set only on a matching signal field code.
// - Status bit 2 shows header CRC validity; zero while disabled.
// - Status bit 1 records antenna at the last valid CRC.
// - Received service field is captured into a read-only register.
// - Received length field is captured into high and low registers.
// - Test-bus select picks the group driving test lines and clock.
// - Code 00h drives test lines and test clock to zero.
// - Code 01h shows receive progress bits, cleared after last chip.
// - Receive monitor bit map: calibration, sense, energy, header steps.
// - Code 02h shows transmit progress bits, cleared after last chip.
// - Transmit monitor bit map; test clock marks symbol boundaries.
// - Code 03h shows latched and live early sense plus strength.
// - Programmed codes feed transmit header and receive rate detection.
// - Delimiter search lasts programmed symbols, then returns to idle.
module hfs_regs (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Receive header path
    input wire logic receive_path_enable,
    input wire logic carrier_acquired,
    input wire logic sfd_found,
    input wire logic symbol_tick,
    input wire logic rx_signal_strobe,
    input wire logic [7:0] rx_signal_byte,
    input wire logic rx_service_strobe,
    input wire logic [7:0] rx_service_byte,
    input wire logic rx_length_strobe,
    input wire logic [15:0] rx_length_word,
    input wire logic rx_crc_strobe,
    input wire logic rx_crc_ok,
    input wire logic antenna_a_selected,
    input wire logic rx_last_chip,
    // Receive monitors
    input wire logic converter_calibration_full_scale,
    input wire logic carrier_sense,
    input wire logic energy_detect,
    input wire logic carrier_sense_early,
    input wire logic strength_pulse,
    input wire logic [5:0] strength,
    input wire logic strength_conv_clk,
    // Transmit monitors
    input wire logic transmit_enable_delayed,
    input wire logic [5:0] tx_field_start,
    input wire logic tx_last_chip,
    input wire logic symbol_boundary_mark,
    // Header and status outputs
    output logic [7:0] tx_service_field,
    output logic [15:0] tx_length_field,
    output logic [7:0] tx_signal_code,
    output hfs_pkg::hfs_rate_t detected_rate,
    output logic sfd_timeout,
    // Test bus
    output logic [7:0] test_out,
    output logic test_clk_out
);
    import hfs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic is_mapped(input logic [7:0] a);
        return (a[1:0] == 2'b00) && (a >= `HFS_A_SFD_TIMER)
            && (a <= `HFS_A_TB_MONITOR);
    endfunction

    function automatic logic is_writable(input logic [7:0] a);
        return is_mapped(a) && (a < `HFS_A_RX_STATUS
            || a == `HFS_A_TB_SELECT);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Storage

    logic [7:0] sfd_timer_r;
    logic [7:0] sig_code_r [0:3];
    logic [7:0] tx_rate_r;
    logic [7:0] tx_service_r;
    logic [7:0] tx_len_hi_r;
    logic [7:0] tx_len_lo_r;
    logic [7:0] test_sel_r;
    logic [7:0] rx_service_r;
    logic [15:0] rx_length_r;
    logic [7:0] tx_code_r;
    hfs_rate_t st_rate_r;
    logic st_sig_r;
    logic st_crc_r;
    logic st_ant_r;
    hfs_srch_t srch_r;
    hfs_srch_t srch_nxt;
    logic [7:0] sfd_cnt_r;
    logic sfd_timeout_r;
    logic mon_sig_r;
    logic mon_len_r;
    logic mon_crc_r;
    logic [5:0] tx_mon_r;
    logic [7:0] test_out_r;
    logic test_clk_r;

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel: address and data taken in either order

    logic awready_r, wready_r, bvalid_r, aw_hold_r, w_hold_r;
    logic [7:0] wr_addr_r;
    logic [7:0] wr_byte_r;
    logic wr_lane_r;
    logic [1:0] bresp_r;

    wire aw_fire = awvalid && awready_r;
    wire w_fire = wvalid && wready_r;
    wire wr_do = aw_hold_r && w_hold_r && !bvalid_r;
    wire aw_hold_nxt = (aw_hold_r || aw_fire) && !wr_do;
    wire w_hold_nxt = (w_hold_r || w_fire) && !wr_do;
    wire wr_ok = is_writable(wr_addr_r);
    // Byte lane 0 carries every field; other lanes are ignored
    wire wr_en = wr_do && wr_ok && wr_lane_r;
    wire wr_sig = (wr_addr_r >= `HFS_A_SIG_CODE0)
        && (wr_addr_r <= `HFS_A_SIG_CODE3);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= `HFS_RESP_OKAY;
            wr_addr_r <= 8'h00;
            wr_byte_r <= 8'h00;
            wr_lane_r <= 1'b0;
        end else begin
            aw_hold_r <= aw_hold_nxt;
            w_hold_r <= w_hold_nxt;
            awready_r <= !aw_hold_nxt;
            wready_r <= !w_hold_nxt;
            if (aw_fire) begin
                wr_addr_r <= awaddr;
            end
            if (w_fire) begin
                wr_byte_r <= wdata[7:0];
                wr_lane_r <= wstrb[0];
            end
            if (wr_do) begin
                bvalid_r <= 1'b1;
                // Read-only and unmapped words answer with an error
                bresp_r <= wr_ok ? `HFS_RESP_OKAY : `HFS_RESP_SLVERR;
            end else if (bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Writable registers

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sfd_timer_r <= `HFS_RST_SFD_TIMER;
            tx_rate_r <= `HFS_RST_BYTE;
            tx_service_r <= `HFS_RST_BYTE;
            tx_len_hi_r <= `HFS_RST_BYTE;
            tx_len_lo_r <= `HFS_RST_BYTE;
            test_sel_r <= `HFS_RST_BYTE;
        end else if (wr_en) begin
            case (wr_addr_r)
                `HFS_A_SFD_TIMER: sfd_timer_r <= wr_byte_r;
                `HFS_A_TX_RATE: tx_rate_r <= wr_byte_r;
                `HFS_A_TX_SERVICE: tx_service_r <= wr_byte_r;
                `HFS_A_TX_LEN_HI: tx_len_hi_r <= wr_byte_r;
                `HFS_A_TX_LEN_LO: tx_len_lo_r <= wr_byte_r;
                `HFS_A_TB_SELECT: test_sel_r <= wr_byte_r;
                default: ;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sig_code_r[0] <= `HFS_RST_CODE0;
            sig_code_r[1] <= `HFS_RST_CODE1;
            sig_code_r[2] <= `HFS_RST_CODE2;
            sig_code_r[3] <= `HFS_RST_CODE3;
        end else if (wr_en && wr_sig) begin
            sig_code_r[wr_addr_r[3:2]] <= wr_byte_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive header status

    // Last matching code wins; codes are expected to be distinct
    logic sig_hit;
    logic [1:0] sig_idx;
    always_comb begin
        sig_hit = 1'b0;
        sig_idx = 2'b00;
        for (int i = 0; i < 4; i++) begin
            if (rx_signal_byte == sig_code_r[i]) begin
                sig_hit = 1'b1;
                sig_idx = 2'(i);
            end
        end
    end

    wire rx_off = !receive_path_enable;
    wire crc_good = rx_crc_strobe && rx_crc_ok && receive_path_enable;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_rate_r <= HFS_RATE_1M;
            st_sig_r <= 1'b0;
            st_crc_r <= 1'b0;
            st_ant_r <= 1'b0;
        end else begin
            if (rx_off) begin
                st_sig_r <= 1'b0;
                st_crc_r <= 1'b0;
            end else begin
                if (rx_signal_strobe) begin
                    st_sig_r <= sig_hit;
                end
                if (rx_signal_strobe && sig_hit) begin
                    st_rate_r <= hfs_rate_t'(sig_idx);
                end
                if (rx_crc_strobe) begin
                    st_crc_r <= rx_crc_ok;
                end
            end
            if (crc_good) begin
                st_ant_r <= antenna_a_selected;
            end
        end
    end

    // Captured fields only move on a new header
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_service_r <= `HFS_RST_BYTE;
            rx_length_r <= 16'h0000;
        end else begin
            if (rx_service_strobe) begin
                rx_service_r <= rx_service_byte;
            end
            if (rx_length_strobe) begin
                rx_length_r <= rx_length_word;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Delimiter search timer

    wire srch_expire = (srch_r == HFS_SRCH_SFD) && !sfd_found
        && symbol_tick && (sfd_cnt_r <= 8'h01);

    always_comb begin
        case (srch_r)
            HFS_SRCH_IDLE:
                srch_nxt = carrier_acquired ? HFS_SRCH_SFD : HFS_SRCH_IDLE;
            HFS_SRCH_SFD:
                srch_nxt = sfd_found ? HFS_SRCH_FOUND
                    : (srch_expire ? HFS_SRCH_IDLE : HFS_SRCH_SFD);
            HFS_SRCH_FOUND:
                srch_nxt = rx_last_chip ? HFS_SRCH_IDLE : HFS_SRCH_FOUND;
            default:
                srch_nxt = HFS_SRCH_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            srch_r <= HFS_SRCH_IDLE;
            sfd_cnt_r <= 8'h00;
            sfd_timeout_r <= 1'b0;
        end else begin
            // Receive disable overrides every transition
            srch_r <= rx_off ? HFS_SRCH_IDLE : srch_nxt;
            sfd_timeout_r <= srch_expire && !rx_off;
            if (srch_r == HFS_SRCH_IDLE) begin
                sfd_cnt_r <= sfd_timer_r;
            end else if (symbol_tick && sfd_cnt_r != 8'h00) begin
                sfd_cnt_r <= sfd_cnt_r - 8'h01;
            end
        end
    end

    wire st_acq = (srch_r != HFS_SRCH_IDLE);
    wire st_sfd = (srch_r == HFS_SRCH_FOUND);

    ////////////////////////////////////////////////////////////////////////
    // Progress monitors for the test bus

    wire rx_mon_clear = rx_last_chip || rx_off;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mon_sig_r <= 1'b0;
            mon_len_r <= 1'b0;
            mon_crc_r <= 1'b0;
            tx_mon_r <= 6'h00;
        end else begin
            mon_sig_r <= !rx_mon_clear && (mon_sig_r || rx_signal_strobe);
            mon_len_r <= !rx_mon_clear && (mon_len_r || rx_length_strobe);
            mon_crc_r <= !rx_mon_clear && (mon_crc_r || crc_good);
            // Start pulses of the frame's fields, cleared at the end
            tx_mon_r <= tx_last_chip ? 6'h00
                : (tx_mon_r | tx_field_start);
        end
    end

    wire [7:0] rx_mon = {converter_calibration_full_scale, carrier_sense,
        energy_detect, 1'b0, st_sfd, mon_sig_r, mon_len_r,
        mon_crc_r};
    wire [7:0] tx_mon = {converter_calibration_full_scale,
        transmit_enable_delayed, tx_mon_r};

    logic [7:0] tb_data;
    logic tb_clk;

    hfs_test_bus u_test_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .sel(hfs_tb_code_t'(test_sel_r)),
        .rx_mon(rx_mon),
        .tx_mon(tx_mon),
        .symbol_boundary_mark(symbol_boundary_mark),
        .carrier_sense_early(carrier_sense_early),
        .strength_pulse(strength_pulse),
        .strength(strength),
        .strength_conv_clk(strength_conv_clk),
        .test_data(tb_data),
        .test_clk(tb_clk)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            test_out_r <= 8'h00;
            test_clk_r <= 1'b0;
            tx_code_r <= 8'h00;
        end else begin
            test_out_r <= tb_data;
            test_clk_r <= tb_clk;
            tx_code_r <= sig_code_r[tx_rate_r[1:0]];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel

    wire [7:0] st_word = {st_rate_r, st_acq, st_sfd, st_sig_r, st_crc_r,
        st_ant_r, 1'b0};
    wire [7:0] rd_a = araddr;
    wire [7:0] rd_byte =
        (rd_a == `HFS_A_SFD_TIMER) ? sfd_timer_r :
        (rd_a == `HFS_A_TX_RATE) ? tx_rate_r :
        (rd_a == `HFS_A_TX_SERVICE) ? tx_service_r :
        (rd_a == `HFS_A_TX_LEN_HI) ? tx_len_hi_r :
        (rd_a == `HFS_A_TX_LEN_LO) ? tx_len_lo_r :
        (rd_a == `HFS_A_RX_STATUS) ? st_word :
        (rd_a == `HFS_A_RX_SERVICE) ? rx_service_r :
        (rd_a == `HFS_A_RX_LEN_HI) ? rx_length_r[15:8] :
        (rd_a == `HFS_A_RX_LEN_LO) ? rx_length_r[7:0] :
        (rd_a == `HFS_A_TB_SELECT) ? test_sel_r :
        (rd_a == `HFS_A_TB_MONITOR) ? test_out_r :
        (rd_a >= `HFS_A_SIG_CODE0 && rd_a <= `HFS_A_SIG_CODE3)
            ? sig_code_r[rd_a[3:2]] : 8'h00;

    logic arready_r, rvalid_r, rd_status_r;
    logic [7:0] rdata_r;
    logic [1:0] rresp_r;
    wire ar_fire = arvalid && arready_r;
    wire rvalid_nxt = ar_fire || (rvalid_r && !rready);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 8'h00;
            rresp_r <= `HFS_RESP_OKAY;
            rd_status_r <= 1'b0;
        end else begin
            arready_r <= !rvalid_nxt;
            rvalid_r <= rvalid_nxt;
            if (ar_fire) begin
                rdata_r <= rd_byte;
                rresp_r <= is_mapped(rd_a) ? `HFS_RESP_OKAY
                    : `HFS_RESP_SLVERR;
                rd_status_r <= (rd_a == `HFS_A_RX_STATUS);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rresp = rresp_r;
    assign rdata = {24'h000000, rdata_r};
    assign tx_service_field = tx_service_r;
    assign tx_length_field = {tx_len_hi_r, tx_len_lo_r};
    assign tx_signal_code = tx_code_r;
    assign detected_rate = st_rate_r;
    assign sfd_timeout = sfd_timeout_r;
    assign test_out = test_out_r;
    assign test_clk_out = test_clk_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_status_lsb_zero: assert property (
        rvalid_r && rd_status_r |-> rdata_r[0] == 1'b0)
        else $error("status bit 0 read as one");
    a_rx_off_search: assert property (
        rx_off |=> !st_acq && !st_sfd)
        else $error("search status not cleared when receive off");
    a_sig_needs_match: assert property (
        $rose(st_sig_r) |-> $past(rx_signal_strobe && sig_hit))
        else $error("signal valid set without a code match");
    a_crc_follows: assert property (
        rx_crc_strobe && !rx_off |=> st_crc_r == $past(rx_crc_ok))
        else $error("crc status does not follow header crc");
    a_antenna_record: assert property (
        $changed(st_ant_r) |-> $past(crc_good))
        else $error("antenna bit changed without valid crc");
    a_tx_length_hi: assert property (
        wr_en && wr_addr_r == `HFS_A_TX_LEN_HI
        |=> tx_length_field[15:8] == $past(wr_byte_r))
        else $error("high length byte not taken");
    a_service_hold: assert property (
        !rx_service_strobe |=> $stable(rx_service_r))
        else $error("service capture changed without header");
    a_quiet_bus: assert property (
        test_sel_r == 8'h00 ##1 test_sel_r == 8'h00
        |-> test_out == 8'h00 && !test_clk_out)
        else $error("quiet test bus not zero");
    a_sfd_expiry: assert property (
        sfd_timeout_r |-> srch_r == HFS_SRCH_IDLE
        && $past(srch_r == HFS_SRCH_SFD && symbol_tick))
        else $error("delimiter timeout without expiry");
    a_tx_code_pick: assert property (
        !wr_en |=> tx_code_r == sig_code_r[tx_rate_r[1:0]])
        else $error("transmit code does not follow rate");

    c_write_done: cover property (wr_en ##[1:4] bvalid_r && bready);
    c_status_read: cover property (ar_fire && rd_a == `HFS_A_RX_STATUS);
    c_sfd_timeout: cover property (sfd_timeout_r);
    c_crc_valid: cover property (crc_good ##1 st_crc_r);

endmodule

//--- hfs_host_model.sv
/* Host partner: AXI4-Lite master with one write and one read task.
   Assumes the register slave shares aclk. */
`timescale 1ns/1ps
module hfs_host_model (
    // Write channels
    input wire logic aclk, output logic [7:0] awaddr,
    output logic [31:0] wdata,
    output logic [3:0] wstrb, output logic awvalid, output logic wvalid,
    output logic bready, input wire logic awready, input wire logic wready,
    input wire logic bvalid, input wire logic [1:0] bresp,
    // Read channels
    output logic [7:0] araddr, output logic arvalid, output logic rready,
    input wire logic arready, input wire logic rvalid,
    input wire logic [1:0] rresp, input wire logic [31:0] rdata
);
    initial {awaddr, wdata, wstrb, awvalid, wvalid, bready, araddr} = '0;
    initial {arvalid, rready} = '0;
    // Slave may take address and data in either order
    task wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'hF;
        {awvalid, wvalid, bready} <= 3'b111;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        do @(posedge aclk); while (!bvalid);
        r = bresp;
        bready <= 0;
        // One idle edge so the next call never reassigns in this step
        @(posedge aclk);
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do @(posedge aclk); while (!arready);
        arvalid <= 0;
        do @(posedge aclk); while (!rvalid);
        {d, r} = {rdata[7:0], rresp};
        rready <= 0;
        @(posedge aclk);
    endtask
endmodule

//--- test_header_field_status_test_bus_regs.sv
/* Bench: host model on the bus, header strobes and monitors from here.
   Assumes one 25 MHz clock. */
`timescale 1ns/1ps
module test_header_field_status_test_bus_regs;
    logic aclk = 0, aresetn = 0, receive_path_enable = 0, sfd_found = 0;
    logic carrier_acquired = 0, symbol_tick = 0, rx_signal_strobe = 0, ant;
    logic rx_service_strobe = 0, rx_length_strobe = 0, rx_crc_strobe = 0;
    logic rx_crc_ok = 0, rx_last_chip = 0, antenna_a_selected = 0;
    logic converter_calibration_full_scale = 0, carrier_sense = 0;
    logic energy_detect = 0, transmit_enable_delayed = 0, tx_last_chip = 0;
    logic symbol_boundary_mark = 0, carrier_sense_early = 0;
    logic strength_conv_clk = 0, strength_pulse = 0, sfd_timeout, test_clk_out;
    logic [5:0] strength = 0, tx_field_start = 0;
    logic [7:0] rx_signal_byte = 0, rx_service_byte = 0, tx_service_field;
    logic [7:0] tx_signal_code, test_out, awaddr, araddr, hi, lo, sv, d, st;
    logic [15:0] rx_length_word = 0, tx_length_field;
    logic [1:0] detected_rate, bresp, rresp, r;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [7:0] codes [4] = '{8'h0A, 8'h14, 8'h37, 8'h6E};
    int n_errors = 0, samples_checked = 0, k;
    hfs_regs u_hfs_regs (.*);
    hfs_host_model host (.*);
    initial forever #20 aclk = ~aclk;
    // Free-running monitor levels keep the test bus selector busy
    always @(posedge aclk)
        {converter_calibration_full_scale, carrier_sense, energy_detect,
         transmit_enable_delayed, symbol_boundary_mark} <= 5'($urandom);
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task rd(input logic [7:0] a, input logic [9:0] e);
        host.rd(a, d, r);
        chk({r, d}, e);
    endtask
    task close_out;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #200000 n_errors++;
        close_out;
    end
    initial begin
        void'($urandom(44188));
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        {hi, lo, sv, st} = $urandom;
        k = $urandom_range(3);
        ant = 1'($urandom);
        host.wr(8'h54, 8'h00, r);
        host.wr(8'h58, hi, r);
        host.wr(8'h5C, lo, r);
        chk({tx_service_field, tx_length_field}, {8'h00, hi, lo});
        host.wr(8'h60, 8'hFF, r);
        chk(r, 2'b10);
        rd(8'h80, 10'h200);
        // Whole header in one cycle right after acquisition, then a second CRC strobe that fails
        {receive_path_enable, carrier_acquired, rx_crc_ok} <= 3'b111;
        {rx_signal_byte, rx_service_byte} <= {codes[k], sv};
        rx_length_word <= {lo, hi};
        antenna_a_selected <= ant;
        @(posedge aclk);
        carrier_acquired <= 0;
        {sfd_found, rx_signal_strobe, rx_service_strobe} <= 3'b111;
        {rx_length_strobe, rx_crc_strobe} <= 2'b11;
        @(posedge aclk);
        {sfd_found, rx_signal_strobe, rx_service_strobe} <= 3'b000;
        {rx_length_strobe, rx_crc_strobe, rx_crc_ok} <= 3'b010;
        antenna_a_selected <= ~ant;
        @(posedge aclk);
        rx_crc_strobe <= 0;
        rd(8'h60, {k[1:0], 4'hE, ant, 1'b0});
        rd(8'h64, {2'b00, sv});
        rd(8'h68, {2'b00, lo});
        rd(8'h6C, {2'b00, hi});
        chk(detected_rate, k);
        host.wr(8'h50, 8'(k), r);
        chk(tx_signal_code, codes[k]);
        receive_path_enable <= 0;
        // Let the disable land before the status read is taken
        @(posedge aclk);
        rd(8'h60, {k[1:0], 4'h0, ant, 1'b0});
        host.wr(8'h3C, 8'h03, r);
        {receive_path_enable, carrier_acquired, symbol_tick} <= 3'b111;
        @(posedge aclk);
        carrier_acquired <= 0;
        repeat (2) @(posedge aclk);
        @(negedge aclk) chk(sfd_timeout, 0);
        @(negedge aclk) chk(sfd_timeout, 1);
        @(posedge aclk) symbol_tick <= 0;
        {strength, carrier_sense_early, strength_pulse} <= {st[5:0], 2'b11};
        strength_conv_clk <= 1;
        host.wr(8'h70, 8'h00, r);
        strength_pulse <= 0;
        chk({test_clk_out, test_out}, 0);
        host.wr(8'h70, 8'h03, r);
        chk({test_clk_out, test_out}, {3'b111, st[5:0]});
        rd(8'h74, {4'b0011, st[5:0]});
        host.wr(8'h70, 8'h02, r);
        tx_field_start <= 6'h21;
        @(posedge aclk) tx_field_start <= 6'h04;
        @(posedge aclk) tx_field_start <= 6'h00;
        repeat (2) @(negedge aclk);
        chk(test_out[5:0], 6'h25);
        @(posedge aclk) tx_last_chip <= 1;
        @(posedge aclk) tx_last_chip <= 0;
        repeat (2) @(negedge aclk);
        chk(test_out[5:0], 6'h00);
        close_out;
    end
endmodule
